// ===== dv/nfsb_ctrl_checker.sv
/*
  port checker for the flash suspend/bypass controller.
  assumes a bind onto nfsb_ctrl and a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module nfsb_ctrl_checker
  import nfsb_pkg::*;
(
  // clock and reset
  input wire logic                SYS_CLK_I,
  input wire logic                RESETN_I,
  // request side
  input wire logic                REQ_VALID_I,
  input wire nfsb_pkg::nfsb_req_t REQ_I,
  input wire logic                REQ_READY_O,
  input wire logic                REFUSED_O,
  // context and modes
  input wire logic                CHIP_ERASE_ACTIVE_I,
  input wire logic                ERASE_SUSPENDED_O,
  input wire logic                PROGRAM_SUSPENDED_O,
  input wire logic                BYPASS_MODE_O,
  input wire logic                HIGH_VOLTAGE_LEVEL_EN_O,
  // flash strobes
  input wire logic                FLASH_DQ_OE_N_O,
  input wire logic                FLASH_CE_N_O,
  input wire logic                FLASH_WE_N_O
);
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);
  // a request is taken on this edge
  logic take;
  assign take = REQ_VALID_I && REQ_READY_O;

  property p_we_drive;
    !FLASH_WE_N_O |-> !FLASH_CE_N_O && !FLASH_DQ_OE_N_O;
  endproperty
  a_we_drive: assert property (p_we_drive)
    else $error("write strobe without chip select or data drive");
  property p_we_width;
    $fell(FLASH_WE_N_O) |-> !FLASH_WE_N_O [*5] ##1 FLASH_WE_N_O;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width off");
  property p_chip;
    CHIP_ERASE_ACTIVE_I && !ERASE_SUSPENDED_O |=> !ERASE_SUSPENDED_O;
  endproperty
  a_chip: assert property (p_chip)
    else $error("erase suspended during chip erase");
  property p_accel;
    $rose(HIGH_VOLTAGE_LEVEL_EN_O) |-> ##[0:2] BYPASS_MODE_O;
  endproperty
  a_accel: assert property (p_accel)
    else $error("high voltage without bypass mode");
  property p_ers_res;
    take && REQ_I.op == NFSB_OP_ERS_RES && !ERASE_SUSPENDED_O |-> ##[1:2] REFUSED_O;
  endproperty
  a_ers_res: assert property (p_ers_res)
    else $error("erase resume accepted when not suspended");
  property p_pgm_res;
    take && REQ_I.op == NFSB_OP_PGM_RES && !PROGRAM_SUSPENDED_O |-> ##[1:2] REFUSED_O;
  endproperty
  a_pgm_res: assert property (p_pgm_res)
    else $error("program resume accepted when not suspended");
  property p_raw;
    take && REQ_I.op == NFSB_OP_RAW_WRITE && BYPASS_MODE_O |-> ##[1:2] REFUSED_O;
  endproperty
  a_raw: assert property (p_raw)
    else $error("raw write accepted in bypass");
  property p_byp_pgm;
    take && REQ_I.op == NFSB_OP_BYP_PGM && !BYPASS_MODE_O |-> ##[1:2] REFUSED_O;
  endproperty
  a_byp_pgm: assert property (p_byp_pgm)
    else $error("bypass program accepted out of bypass");
endmodule : nfsb_ctrl_checker

bind nfsb_ctrl nfsb_ctrl_checker u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .REQ_VALID_I(REQ_VALID_I),
  .REQ_I(REQ_I), .REQ_READY_O(REQ_READY_O), .REFUSED_O(REFUSED_O),
  .CHIP_ERASE_ACTIVE_I(CHIP_ERASE_ACTIVE_I), .ERASE_SUSPENDED_O(ERASE_SUSPENDED_O),
  .PROGRAM_SUSPENDED_O(PROGRAM_SUSPENDED_O), .BYPASS_MODE_O(BYPASS_MODE_O),
  .HIGH_VOLTAGE_LEVEL_EN_O(HIGH_VOLTAGE_LEVEL_EN_O), .FLASH_DQ_OE_N_O(FLASH_DQ_OE_N_O),
  .FLASH_CE_N_O(FLASH_CE_N_O), .FLASH_WE_N_O(FLASH_WE_N_O)
);
`default_nettype wire

// ===== dv/nfsb_flash_model.sv
/*
  behavioural flash device: logs write cycles, tracks erase suspend and
  answers reads. assumes strobes from the host, no clock of its own.
*/
`timescale 1ns/10ps
`default_nettype none
module nfsb_flash_model
  import nfsb_pkg::*;
(
  // pins from the host
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] dq_i,
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic              ers_act_i,
  // data toward the host
  output logic [DATA_W-1:0]      dq_o
);
  logic [ADDR_W-1:0] wa [0:15];
  logic [DATA_W-1:0] wd [0:15];
  int                nw = 0;
  logic              susp = 1'b0;
  logic              tgl = 1'b0;
  logic [DATA_W-1:0] last = 16'h0000;
  // log every write at the rising strobe, addresses latched there
  always @(posedge we_n_i)
  begin
    if (!ce_n_i)
    begin
      wa[nw % 16] = addr_i;
      wd[nw % 16] = dq_i;
      nw = nw + 1;
      if (dq_i == CMD_SUSPEND && ers_act_i)
        susp = 1'b1;
      if (dq_i == CMD_RESUME)
        susp = 1'b0;
    end
  end
  // status or array data
  // address and strobe leave one register together: settle before reading
  always @(negedge oe_n_i)
  begin
    #1;
    tgl = ~tgl;
    if (susp && addr_i[25:16] == 10'h001)
      last = {8'h00, 1'b1, 1'b0, 3'b000, tgl, 2'b00};
    else
      last = addr_i[15:0] ^ 16'h5a5a;
  end
  // released bus shows the inverse so stale data never passes
  assign dq_o = (!oe_n_i && !ce_n_i) ? last : ~last;
endmodule : nfsb_flash_model
`default_nettype wire

// ===== dv/tb_top.sv
/*
  self-checking bench for nfsb_ctrl with the flash model on its pins.
  assumes the package constants; inputs change at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import nfsb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, se = 1'b0, ce_act = 1'b0;
  logic pa = 1'b0, acc = 1'b0, rdy, done, refd, esus, psus, byp, hv;
  logic fdoe_n, fce_n, foe_n, fwe_n, r;
  nfsb_req_t req = '0;
  logic [15:0] rdata, fdo, rd1;
  wire logic [15:0] fdi;
  logic [25:0] fa;
  int mismatches = 0, compares = 0, n0, lat;

  nfsb_ctrl u_dut (.SYS_CLK_I(clk), .RESETN_I(rst_n), .REQ_VALID_I(vld), .REQ_I(req),
    .REQ_READY_O(rdy), .DONE_O(done), .REFUSED_O(refd), .RDATA_O(rdata),
    .SECTOR_ERASE_ACTIVE_I(se), .CHIP_ERASE_ACTIVE_I(ce_act), .PROGRAM_ACTIVE_I(pa),
    .ACCEL_REQ_I(acc), .ERASE_SUSPENDED_O(esus), .PROGRAM_SUSPENDED_O(psus),
    .BYPASS_MODE_O(byp), .HIGH_VOLTAGE_LEVEL_EN_O(hv), .FLASH_ADDR_O(fa),
    .FLASH_DQ_O(fdo), .FLASH_DQ_OE_N_O(fdoe_n), .FLASH_DQ_I(fdi),
    .FLASH_CE_N_O(fce_n), .FLASH_OE_N_O(foe_n), .FLASH_WE_N_O(fwe_n));
  nfsb_flash_model u_model (.addr_i(fa), .dq_i(fdo), .ce_n_i(fce_n), .oe_n_i(foe_n),
    .we_n_i(fwe_n), .ers_act_i(se), .dq_o(fdi));

  // free-running 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
  begin
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask : chk

  // compare the k-th write logged since the last request
  task automatic chk_w(input int k, input logic [25:0] a, input logic [15:0] d);
  begin
    chk({6'h00, u_model.wa[(n0 + k) % 16]}, {6'h00, a});
    chk({16'h0000, u_model.wd[(n0 + k) % 16]}, {16'h0000, d});
  end
  endtask : chk_w

  // one request, held until taken; bounded wait for the done pulse
  task automatic issue(input nfsb_op_t op, input logic [25:0] a, input logic [15:0] d);
  begin
    n0 = u_model.nw;
    lat = 0;
    vld = 1'b1;
    req = '{op, a, d};
    while (rdy !== 1'b1 && lat < 50)
    begin
      @(negedge clk);
      lat++;
    end
    if (rdy !== 1'b1)
    begin
      mismatches++;
      print_verdict;
    end
    @(negedge clk);
    vld = 1'b0;
    lat = 0;
    while (done !== 1'b1)
    begin
      @(negedge clk);
      lat++;
      if (lat > 4000)
      begin
        mismatches++;
        print_verdict;
      end
    end
    r = refd;
    // one edge apart, so a refused request never flips vld twice in a step
    @(negedge clk);
  end
  endtask : issue

  task automatic wait_hv(input logic v);
  begin
    lat = 0;
    while (hv !== v && lat < 50)
    begin
      @(negedge clk);
      lat++;
    end
    if (hv !== v)
    begin
      mismatches++;
      print_verdict;
    end
  end
  endtask : wait_hv

  task automatic t_bypass;
  begin
    chk({rdy, fwe_n, fce_n, foe_n, fdoe_n, byp, hv}, 7'h7c);
    issue(NFSB_OP_BYP_ENTRY, 26'h0, 16'h0);
    chk(u_model.nw - n0, 3);
    chk_w(0, ADDR_UNLOCK1, CMD_UNLOCK1);
    chk_w(1, ADDR_UNLOCK2, CMD_UNLOCK2);
    chk_w(2, ADDR_UNLOCK1, CMD_BYP_ENTRY);
    chk(byp, 1'b1);
    issue(NFSB_OP_BYP_PGM, 26'h0012345, 16'hbeef);
    chk_w(0, ADDR_ANY, CMD_PGM_SETUP);
    chk_w(1, 26'h0012345, 16'hbeef);
    issue(NFSB_OP_RAW_WRITE, 26'h0000555, 16'h0080);
    chk({r, byp, u_model.nw != n0}, 3'b110);
    issue(NFSB_OP_ABORT_RST, 26'h0, 16'h0);
    chk_w(2, ADDR_UNLOCK1, CMD_ABORT_RST);
    issue(NFSB_OP_BYP_EXIT, 26'h0, 16'h0);
    chk_w(0, ADDR_ANY, CMD_BYP_EXIT1);
    chk_w(1, ADDR_ANY, CMD_BYP_EXIT2);
    chk(byp, 1'b0);
    issue(NFSB_OP_BYP_PGM, 26'h0, 16'h1234);
    chk({r, u_model.nw != n0}, 2'b10);
    $display("test bypass done");
  end
  endtask : t_bypass

  task automatic t_erase;
  begin
    ce_act = 1'b1;
    issue(NFSB_OP_ERS_SUSP, 26'h0, 16'h0);
    chk({r, esus, u_model.nw != n0}, 3'b100);
    ce_act = 1'b0;
    se = 1'b1;
    issue(NFSB_OP_ERS_SUSP, 26'h0, 16'h0);
    chk_w(0, ADDR_ANY, CMD_SUSPEND);
    chk({r, esus}, 2'b01);
    chk(lat >= ERS_SUSP_CYC && lat <= ERS_SUSP_CYC + 40, 1);
    issue(NFSB_OP_READ, 26'h0010004, 16'h0);
    rd1 = rdata;
    issue(NFSB_OP_READ, 26'h0010004, 16'h0);
    chk(rd1[7], 1'b1);
    chk(rd1[2] ^ rdata[2], 1'b1);
    chk(rd1[6] ^ rdata[6], 1'b0);
    issue(NFSB_OP_READ, 26'h0020004, 16'h0);
    chk(rdata, 16'h0004 ^ 16'h5a5a);
    issue(NFSB_OP_ERS_RES, 26'h0, 16'h0);
    chk_w(0, ADDR_ANY, CMD_RESUME);
    chk({r, esus}, 2'b00);
    issue(NFSB_OP_ERS_RES, 26'h0, 16'h0);
    chk({r, u_model.nw != n0}, 2'b10);
    se = 1'b0;
    $display("test erase suspend done");
  end
  endtask : t_erase

  task automatic t_pgm;
  begin
    pa = 1'b1;
    issue(NFSB_OP_PGM_SUSP, 26'h0, 16'h0);
    chk_w(0, ADDR_ANY, CMD_SUSPEND);
    chk({r, psus}, 2'b01);
    chk(lat >= PGM_SUSP_CYC && lat <= PGM_SUSP_CYC + 40, 1);
    issue(NFSB_OP_PGM_RES, 26'h0, 16'h0);
    chk_w(0, ADDR_ANY, CMD_RESUME);
    chk({r, psus}, 2'b00);
    issue(NFSB_OP_PGM_RES, 26'h0, 16'h0);
    chk(r, 1'b1);
    pa = 1'b0;
    $display("test program suspend done");
  end
  endtask : t_pgm

  task automatic t_accel;
  begin
    acc = 1'b1;
    wait_hv(1'b1);
    chk({hv, byp}, 2'b11);
    issue(NFSB_OP_BYP_EXIT, 26'h0, 16'h0);
    chk({r, byp}, 2'b11);
    acc = 1'b0;
    wait_hv(1'b0);
    chk({hv, byp}, 2'b00);
    $display("test accelerate done");
  end
  endtask : t_accel

  // mid-run reset drops every mode the host was tracking
  task automatic t_reset;
  begin
    issue(NFSB_OP_BYP_ENTRY, 26'h0, 16'h0);
    chk(byp, 1'b1);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({rdy, done, byp, esus, psus, hv}, 6'h20);
    @(negedge clk);
    chk({rdy, fwe_n, fce_n, foe_n, byp}, 5'h1e);
    $display("test reset done");
  end
  endtask : t_reset

  // reset for four cycles, then the scenarios in turn
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_bypass;
    t_erase;
    t_pgm;
    t_accel;
    t_reset;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire

// ===== logic/nfsb_bus_cycle.sv
/*
  one asynchronous flash bus cycle: a write pulse on we or a read on oe.
  assumes the request is held stable by the caller only in the start cycle
  and that dq_sync_i already passed a two-stage synchroniser.
*/
`timescale 1ns/10ps
`default_nettype none
module nfsb_bus_cycle
  import nfsb_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // cycle request
  input  wire logic                  start_i,
  input  wire nfsb_pkg::nfsb_cyc_t   cyc_i,
  output logic                       busy_o,
  output logic                       done_o,
  // pins and read data
  input  wire logic [DATA_W-1:0]     dq_sync_i,
  output nfsb_pkg::nfsb_pins_t       pins_o,
  output logic [DATA_W-1:0]          rdata_o
);
  typedef enum logic [1:0] {BC_IDLE, BC_ACT, BC_REC} nfsb_bc_st_t;
  typedef struct packed {
    nfsb_bc_st_t       st;
    logic [CNT_W-1:0]  cnt;
    nfsb_cyc_t         cyc;
    nfsb_pins_t        pins;
    logic [DATA_W-1:0] rdata;
    logic              done;
  } nfsb_bc_state_t;
  nfsb_bc_state_t s_q, s_d;

  // strobe sequencing: active phase then recovery with strobes high
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      BC_IDLE:
      begin
        if (start_i)
        begin
          s_d.st           = BC_ACT;
          s_d.cyc          = cyc_i;
          s_d.pins.addr    = cyc_i.addr;
          s_d.pins.dq_out  = cyc_i.data;
          s_d.pins.dq_oe_n = ~cyc_i.wr;
          s_d.pins.ce_n    = 1'b0;
          s_d.pins.we_n    = ~cyc_i.wr;
          s_d.pins.oe_n    = cyc_i.wr;
          s_d.cnt          = cyc_i.wr ? CNT_W'(WE_LOW_CYC) : CNT_W'(RD_CYC);
        end
      end
      BC_ACT:
      begin
        if (s_q.cnt > CNT_W'(1))
          s_d.cnt = s_q.cnt - CNT_W'(1);
        else
        begin
          // data latched by the flash on the rising we edge
          s_d.st        = BC_REC;
          s_d.pins.we_n = 1'b1;
          s_d.pins.oe_n = 1'b1;
          s_d.rdata     = s_q.cyc.wr ? s_q.rdata : dq_sync_i;
          s_d.cnt       = CNT_W'(WE_HIGH_CYC);
        end
      end
      BC_REC:
      begin
        if (s_q.cnt > CNT_W'(1))
          s_d.cnt = s_q.cnt - CNT_W'(1);
        else
        begin
          s_d.st           = BC_IDLE;
          s_d.pins.ce_n    = 1'b1;
          s_d.pins.dq_oe_n = 1'b1;
          s_d.done         = 1'b1;
        end
      end
      default: s_d.st = BC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_q         <= '0;
      s_q.st      <= BC_IDLE;
      s_q.pins    <= '{addr: '0, dq_out: '0, dq_oe_n: 1'b1, ce_n: 1'b1,
                       oe_n: 1'b1, we_n: 1'b1};
    end
    else
      s_q <= s_d;
  end

  assign busy_o  = (s_q.st != BC_IDLE);
  assign done_o  = s_q.done;
  assign pins_o  = s_q.pins;
  assign rdata_o = s_q.rdata;
endmodule : nfsb_bus_cycle
`default_nettype wire

// ===== logic/nfsb_ctrl.sv
/*
  host-side controller for suspend/resume, accelerated programming and
  unlock bypass of an asynchronous parallel nor flash. it turns one request
  into the flash bus cycles and tracks which device mode it has left.
  assumes the flash pins meet a board-level tristate resolved outside, and
  that the accelerate high voltage is switched by an external driver.
*/
// Behaviour
// [R1] suspend only during sector erase or window
// [R2] no erase suspend during chip erase
// [R3] wait up to 20 us for erase suspend
// [R4] suspend in window suspends at once
// [R5] suspended erase allows reads, programs elsewhere
// [R6] suspended-sector reads return status
// [R7] suspended program returns to suspend-read
// [R8] identification read allowed while erase-suspended
// [R9] resume erase with 0030h, once
// [R10] suspend code also suspends programming
// [R11] wait up to 15 us for program suspend
// [R12] program suspend allowed under erase suspend
// [R13] identification read allowed under program suspend
// [R14] resume program with 0030h, once
// [R15] high voltage enters bypass automatically
// [R16] bypass abort uses full three-cycle reset
// [R17] accelerate at most ten times, unlocked; high voltage entries are not counted
// [R18] bypass entry: two unlocks then 0020h
// [R19] bypass program: 00a0h then address/data
// [R20] bypass honours only listed commands
// [R21] bypass exit: 90h then 00h
// [R22] toggle bit one stops on erase suspend
// [R23] toggle bit two toggles in erase sectors
// [R24] bypass ignores other commands
`timescale 1ns/10ps
`default_nettype none
module nfsb_ctrl
  import nfsb_pkg::*;
#(
  parameter int MAX_CYCLES = 3
)
(
  // clock and reset
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RESETN_I,
  // request port
  input  wire logic                  REQ_VALID_I,
  input  wire nfsb_pkg::nfsb_req_t   REQ_I,
  output logic                       REQ_READY_O,
  output logic                       DONE_O,
  output logic                       REFUSED_O,
  output logic [DATA_W-1:0]          RDATA_O,
  // device operation context from the host system
  input  wire logic                  SECTOR_ERASE_ACTIVE_I,
  input  wire logic                  CHIP_ERASE_ACTIVE_I,
  input  wire logic                  PROGRAM_ACTIVE_I,
  input  wire logic                  ACCEL_REQ_I,
  // mode status
  output logic                       ERASE_SUSPENDED_O,
  output logic                       PROGRAM_SUSPENDED_O,
  output logic                       BYPASS_MODE_O,
  output logic                       HIGH_VOLTAGE_LEVEL_EN_O,
  // flash pins
  output logic [ADDR_W-1:0]          FLASH_ADDR_O,
  output logic [DATA_W-1:0]          FLASH_DQ_O,
  output logic                       FLASH_DQ_OE_N_O,
  input  wire logic [DATA_W-1:0]     FLASH_DQ_I,
  output logic                       FLASH_CE_N_O,
  output logic                       FLASH_OE_N_O,
  output logic                       FLASH_WE_N_O
);
  if (MAX_CYCLES < 3)
  begin : g_bad_max_cycles
    $error("MAX_CYCLES must cover the three-cycle sequences");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_SETTLE} nfsb_st_t;
  typedef struct packed {
    nfsb_st_t          st;
    nfsb_req_t         req;
    logic [1:0]        idx;
    logic [1:0]        num;
    logic              ers_susp;
    logic              pgm_susp;
    logic              bypass;
    logic              accel;
    logic [WAIT_W-1:0] wait_cnt;
    logic              done;
    logic              refused;
    logic [DATA_W-1:0] rdata;
  } nfsb_state_t;
  nfsb_state_t s_q, s_d;

  logic [DATA_W-1:0] dq_meta_q, dq_sync_q;
  logic              bc_start, bc_busy, bc_done;
  nfsb_cyc_t         bc_cyc;
  nfsb_pins_t        pins;
  logic [DATA_W-1:0] bc_rdata;

  // number of bus cycles a request takes
  function automatic logic [1:0] op_cycles(input nfsb_op_t op);
    case (op)
      // [R18] three-cycle entry
      NFSB_OP_BYP_ENTRY, NFSB_OP_ABORT_RST: op_cycles = 2'd3;
      NFSB_OP_BYP_PGM, NFSB_OP_BYP_EXIT:    op_cycles = 2'd2;
      default:                              op_cycles = 2'd1;
    endcase
  endfunction : op_cycles

  // bus cycle i of a request
  function automatic nfsb_cyc_t op_cycle(input nfsb_req_t r, input logic [1:0] i);
    op_cycle = '{wr: 1'b1, addr: ADDR_ANY, data: r.data};
    case (r.op)
      NFSB_OP_READ:
        op_cycle = '{wr: 1'b0, addr: r.addr, data: '0};
      // [R1] [R10] suspend code at any address
      NFSB_OP_ERS_SUSP, NFSB_OP_PGM_SUSP:
        op_cycle.data = CMD_SUSPEND;
      // [R9] resume code at any address
      NFSB_OP_ERS_RES, NFSB_OP_PGM_RES:
        op_cycle.data = CMD_RESUME;
      // [R16] [R18] unlock-unlock then the reset or the bypass entry code
      NFSB_OP_BYP_ENTRY, NFSB_OP_ABORT_RST:
      begin
        op_cycle.addr = (i == 2'd1) ? ADDR_UNLOCK2 : ADDR_UNLOCK1;
        op_cycle.data = (i == 2'd0) ? CMD_UNLOCK1 : (i == 2'd1) ? CMD_UNLOCK2 :
                        (r.op == NFSB_OP_BYP_ENTRY) ? CMD_BYP_ENTRY : CMD_ABORT_RST;
      end
      // [R19] setup then address and data
      NFSB_OP_BYP_PGM:
      begin
        op_cycle.addr = (i == 2'd0) ? ADDR_ANY : r.addr;
        op_cycle.data = (i == 2'd0) ? CMD_PGM_SETUP : r.data;
      end
      // [R21] exit pair
      NFSB_OP_BYP_EXIT:
        op_cycle.data = (i == 2'd0) ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2;
      default:
        op_cycle.addr = r.addr;
    endcase
  endfunction : op_cycle

  // whether the request is meaningful in the present mode
  function automatic logic op_legal(input nfsb_op_t op, input nfsb_state_t s);
    case (op)
      // [R2] never suspend a chip erase
      NFSB_OP_ERS_SUSP:  op_legal = SECTOR_ERASE_ACTIVE_I && !CHIP_ERASE_ACTIVE_I
                                    && !s.ers_susp;
      // [R12] program suspend also under erase suspend
      NFSB_OP_PGM_SUSP:  op_legal = PROGRAM_ACTIVE_I && !s.pgm_susp;
      // [R14] repeated resume is pointless, refused
      NFSB_OP_ERS_RES:   op_legal = s.ers_susp && !s.pgm_susp;
      NFSB_OP_PGM_RES:   op_legal = s.pgm_susp;
      NFSB_OP_BYP_ENTRY: op_legal = !s.bypass;
      NFSB_OP_BYP_PGM,
      NFSB_OP_BYP_EXIT:  op_legal = s.bypass && !(op == NFSB_OP_BYP_EXIT && s.accel);
      // [R20] raw commands not sent into bypass
      NFSB_OP_RAW_WRITE: op_legal = !s.bypass;
      // [R5] [R8] [R13] reads always go out
      default:           op_legal = 1'b1;
    endcase
  endfunction : op_legal

  // flash data pins cross from outside: two flops
  always_ff @(posedge SYS_CLK_I)
  begin
    dq_meta_q <= FLASH_DQ_I;
    dq_sync_q <= dq_meta_q;
  end

  // request sequencing and mode tracking
  always_comb
  begin
    s_d         = s_q;
    s_d.done    = 1'b0;
    s_d.refused = 1'b0;
    bc_start    = 1'b0;
    bc_cyc      = op_cycle(s_q.req, s_q.idx);
    // [R15] high voltage puts the device in bypass
    if (ACCEL_REQ_I && s_q.st == ST_IDLE && !s_q.accel)
    begin
      s_d.accel  = 1'b1;
      s_d.bypass = 1'b1;
    end
    // [R17] drop high voltage only once programming is done
    else if (!ACCEL_REQ_I && s_q.accel && !PROGRAM_ACTIVE_I && s_q.st == ST_IDLE)
    begin
      s_d.accel  = 1'b0;
      s_d.bypass = 1'b0;
    end
    case (s_q.st)
      ST_IDLE:
      begin
        if (REQ_VALID_I)
        begin
          if (op_legal(REQ_I.op, s_q))
          begin
            s_d.st  = ST_ISSUE;
            s_d.req = REQ_I;
            s_d.idx = 2'd0;
            s_d.num = op_cycles(REQ_I.op);
          end
          else
          begin
            // [R24] illegal commands never reach the pins
            s_d.refused = 1'b1;
            s_d.done    = 1'b1;
          end
        end
      end
      ST_ISSUE:
      begin
        bc_start = 1'b1;
        s_d.st   = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (bc_done)
        begin
          if (s_q.idx + 2'd1 < s_q.num)
          begin
            s_d.idx = s_q.idx + 2'd1;
            s_d.st  = ST_ISSUE;
          end
          else
          begin
            s_d.rdata = bc_rdata;
            s_d.st    = ST_SETTLE;
            case (s_q.req.op)
              // [R3] allow the worst-case erase suspend latency
              NFSB_OP_ERS_SUSP: s_d.wait_cnt = WAIT_W'(ERS_SUSP_CYC);
              // [R11] allow the worst-case program suspend latency
              NFSB_OP_PGM_SUSP: s_d.wait_cnt = WAIT_W'(PGM_SUSP_CYC);
              default:          s_d.wait_cnt = WAIT_W'(1);
            endcase
            case (s_q.req.op)
              // [R4] [R7] now suspended; a program leaves it set
              NFSB_OP_ERS_SUSP:  s_d.ers_susp = 1'b1;
              NFSB_OP_PGM_SUSP:  s_d.pgm_susp = 1'b1;
              NFSB_OP_ERS_RES:   s_d.ers_susp = 1'b0;
              NFSB_OP_PGM_RES:   s_d.pgm_susp = 1'b0;
              NFSB_OP_BYP_ENTRY: s_d.bypass   = 1'b1;
              NFSB_OP_BYP_EXIT:  s_d.bypass   = 1'b0;
              default:           s_d.bypass   = s_q.bypass;
            endcase
          end
        end
      end
      ST_SETTLE:
      begin
        if (s_q.wait_cnt > WAIT_W'(1))
          s_d.wait_cnt = s_q.wait_cnt - WAIT_W'(1);
        else
        begin
          s_d.st   = ST_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
    begin
      s_q    <= '0;
      s_q.st <= ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  // single bus-cycle engine shared by every sequence
  nfsb_bus_cycle u_bus (
    .clk_i     (SYS_CLK_I),
    .rst_n_i   (RESETN_I),
    .start_i   (bc_start),
    .cyc_i     (bc_cyc),
    .busy_o    (bc_busy),
    .done_o    (bc_done),
    .dq_sync_i (dq_sync_q),
    .pins_o    (pins),
    .rdata_o   (bc_rdata)
  );

  // [R6] [R22] [R23] status reads pass through untouched as read data
  assign RDATA_O                 = s_q.rdata;
  assign REQ_READY_O             = (s_q.st == ST_IDLE) && !bc_busy;
  assign DONE_O                  = s_q.done;
  assign REFUSED_O               = s_q.refused;
  assign ERASE_SUSPENDED_O       = s_q.ers_susp;
  assign PROGRAM_SUSPENDED_O     = s_q.pgm_susp;
  assign BYPASS_MODE_O           = s_q.bypass;
  assign HIGH_VOLTAGE_LEVEL_EN_O = s_q.accel;
  assign FLASH_ADDR_O            = pins.addr;
  assign FLASH_DQ_O              = pins.dq_out;
  assign FLASH_DQ_OE_N_O         = pins.dq_oe_n;
  assign FLASH_CE_N_O            = pins.ce_n;
  assign FLASH_OE_N_O            = pins.oe_n;
  assign FLASH_WE_N_O            = pins.we_n;
endmodule : nfsb_ctrl
`default_nettype wire

// ===== logic/nfsb_pkg.sv
/*
  package for the nor flash suspend/bypass host controller: command codes,
  unlock addresses, bus timing counts and the request/pin carrier structs.
  assumes a 16-bit word-addressed asynchronous parallel nor flash.
*/
`default_nettype none
package nfsb_pkg;
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  // command codes
  localparam logic [15:0] CMD_UNLOCK1   = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2   = 16'h0055;
  localparam logic [15:0] CMD_BYP_ENTRY = 16'h0020;
  localparam logic [15:0] CMD_PGM_SETUP = 16'h00a0;
  localparam logic [15:0] CMD_SUSPEND   = 16'h00b0;
  localparam logic [15:0] CMD_RESUME    = 16'h0030;
  localparam logic [15:0] CMD_BYP_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_ABORT_RST = 16'h00f0;
  // unlock word addresses
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1 = 26'h0000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2 = 26'h00002aa;
  localparam logic [ADDR_W-1:0] ADDR_ANY     = 26'h0000000;
  // bus timing: clock rate and write/read strobe widths
  localparam int CLK_MHZ      = 100;
  localparam int WE_LOW_NS    = 50;
  localparam int WE_HIGH_NS   = 30;
  localparam int RD_ACCESS_NS = 100;
  localparam int WE_LOW_CYC   = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_HIGH_CYC  = (WE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC       = (RD_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 8;
  // erase suspend worst-case latency and program suspend latency
  localparam int ERS_SUSP_US  = 20;
  localparam int PGM_SUSP_US  = 15;
  localparam int ERS_SUSP_CYC = ERS_SUSP_US * CLK_MHZ;
  localparam int PGM_SUSP_CYC = PGM_SUSP_US * CLK_MHZ;
  localparam int WAIT_W       = 12;
  // host operations
  typedef enum logic [3:0] {
    NFSB_OP_READ, NFSB_OP_ERS_SUSP, NFSB_OP_ERS_RES, NFSB_OP_PGM_SUSP,
    NFSB_OP_PGM_RES, NFSB_OP_BYP_ENTRY, NFSB_OP_BYP_PGM, NFSB_OP_BYP_EXIT,
    NFSB_OP_ABORT_RST, NFSB_OP_RAW_WRITE
  } nfsb_op_t;
  typedef struct packed {
    nfsb_op_t          op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nfsb_req_t;
  // one bus cycle toward the flash
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nfsb_cyc_t;
  // flash pins driven by the host
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } nfsb_pins_t;
endpackage : nfsb_pkg
`default_nettype wire
